// >>> adc_props.sv
// checker watching the debug control register ports
`timescale 1ns/1ps
module adc_props (
  input wire        clk,
  input wire        rst,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire        reg_rvalid_q,
  input wire [1:0]  startup_method,
  input wire        speed_detect_enable,
  input wire [8:0]  align_angle_cfg,
  input wire [8:0]  forced_angle_cmd,
  input wire        motor_enable,
  input wire        step_done,
  input wire [14:0] speed_ref_q,
  input wire        digital_source_q,
  input wire [2:0]  startup_state_q,
  input wire        closed_loop_q,
  input wire [8:0]  align_angle_q
);
  reg  [31:0] sh_q;                                  // shadow of the stored word
  wire        hit = reg_wr && reg_addr == 8'hEC;     // write to the mapped offset
  wire        adv = step_done && motor_enable;       // an advance request
  // shadow tracks writes so hold bits can be judged from the ports alone
  always @(posedge clk or posedge rst)
    if (rst) sh_q <= 32'h0000_0000;
    else if (hit) sh_q <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rvalid; reg_rd |=> reg_rvalid_q; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_rsv; reg_rvalid_q |-> reg_rdata_q[9:0] == 10'h000; endproperty
  a_rsv: assert property (p_rsv) else $error("low bits not zero");
  property p_unmap; reg_rd && reg_addr != 8'hEC |=> reg_rdata_q == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_loop; hit && reg_wdata[15] |=> ##1 !closed_loop_q; endproperty
  a_loop: assert property (p_loop) else $error("loop stayed closed");
  property p_src;
    hit && reg_wdata[31] |=> ##1 digital_source_q && speed_ref_q == $past(reg_wdata[30:16], 2);
  endproperty
  a_src: assert property (p_src) else $error("digital field not selected");
  property p_align;
    adv && sh_q[14] && startup_state_q == 3'h2 && !startup_method[1] |=> startup_state_q == 3'h2;
  endproperty
  a_align: assert property (p_align) else $error("align not held");
  property p_hold;
    adv && ((sh_q[13] && startup_state_q == 3'h3 && startup_method == 2'h2)
      || (sh_q[12] && startup_state_q == 3'h4 && startup_method == 2'h3)
      || (sh_q[11] && startup_state_q == 3'h1 && speed_detect_enable)) |=> $stable(startup_state_q);
  endproperty
  a_hold: assert property (p_hold) else $error("start-up state not held");
  property p_angle;
    !$past(rst) |-> align_angle_q == ($past(sh_q[10]) ? $past(forced_angle_cmd) % 9'h168
      : $past(align_angle_cfg));
  endproperty
  a_angle: assert property (p_angle) else $error("align angle wrong");
  c_align: cover property (adv && sh_q[14] && startup_state_q == 3'h2);
  c_unmap: cover property (reg_rd && reg_addr != 8'hEC);
  c_closed: cover property (closed_loop_q);
endmodule
bind algo_debug_ctrl adc_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .startup_method(startup_method),
  .speed_detect_enable(speed_detect_enable), .align_angle_cfg(align_angle_cfg),
  .forced_angle_cmd(forced_angle_cmd), .motor_enable(motor_enable), .step_done(step_done),
  .speed_ref_q(speed_ref_q), .digital_source_q(digital_source_q),
  .startup_state_q(startup_state_q), .closed_loop_q(closed_loop_q),
  .align_angle_q(align_angle_q));

// >>> algo_debug_ctrl.v
// algorithm debug control register with speed source, loop and start-up forcing logic
`timescale 1ns/1ps
`include "algo_debug_defs.vh"

// Contract
// [R01] selector set: speed from digital field
// [R02] selector clear: speed from configured input
// [R03] digital field bits 30:16, also mode 2
// [R04] digital field scales to percent of 32768
// [R05] loop-off bit forces open-loop commutation
// [R06] bit 14 holds align for align methods
// [R07] bit 13 holds slow first cycle
// [R08] bit 12 holds position detection state
// [R09] bit 11 holds speed detection when enabled
// [R10] bit 10 picks forced align angle source
// [R11] register resets to all zero
// [R12] forced angle applied modulo 360 degrees
// [R13] bits 9:0 read zero, writes ignored
module algo_debug_ctrl (
  clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata_q,
  reg_rvalid_q,
  speed_mode,
  input_speed_ref,
  startup_method,
  speed_detect_enable,
  align_angle_cfg,
  forced_angle_cmd,
  motor_enable,
  step_done,
  speed_ref_q,
  speed_pct_q,
  digital_source_q,
  startup_state_q,
  closed_loop_q,
  align_angle_q
);
  input  wire        clk;                  // 40 MHz system clock
  input  wire        rst;                  // asynchronous reset, active high
  input  wire [7:0]  reg_addr;             // register offset from the serial target
  input  wire [31:0] reg_wdata;            // write word
  input  wire        reg_wr;               // one-cycle write strobe
  input  wire        reg_rd;               // one-cycle read strobe
  output reg  [31:0] reg_rdata_q;          // read word
  output reg         reg_rvalid_q;         // read answer pulse
  input  wire [1:0]  speed_mode;           // configured speed input mode
  input  wire [14:0] input_speed_ref;      // reference from analog, pwm or frequency decoder
  input  wire [1:0]  startup_method;       // configured start-up method
  input  wire        speed_detect_enable;  // initial speed detection enabled
  input  wire [8:0]  align_angle_cfg;      // configured align angle, degrees
  input  wire [8:0]  forced_angle_cmd;     // commanded forced align angle, degrees
  input  wire        motor_enable;         // run request from the algorithm
  input  wire        step_done;            // pulse: current start-up phase finished
  output reg  [14:0] speed_ref_q;          // selected speed reference
  output reg  [6:0]  speed_pct_q;          // selected reference in whole percent
  output reg         digital_source_q;     // digital field is the active source
  output reg  [2:0]  startup_state_q;      // sequencer state
  output reg         closed_loop_q;        // closed-loop control active
  output reg  [8:0]  align_angle_q;        // angle applied in align state

  // sequencer states
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SPEED  = 3'h1;
  localparam [2:0] ST_ALIGN  = 3'h2;
  localparam [2:0] ST_SLOW   = 3'h3;
  localparam [2:0] ST_POS    = 3'h4;
  localparam [2:0] ST_OPEN   = 3'h5;
  localparam [2:0] ST_CLOSED = 3'h6;

  reg  [31:0] ctrl_q;       // stored register contents
  reg         align_pass_q; // first pass of a double align done
  reg         align_pass_d; // next first-pass flag
  reg  [2:0]  state_d;      // next sequencer state
  reg  [2:0]  method_state; // state that the start-up method enters
  wire        use_digital;  // digital field drives the reference
  wire [14:0] dig_speed;    // digital speed field
  wire [14:0] speed_sel;    // selected reference
  wire [21:0] pct_product;  // reference times 100
  wire [8:0]  forced_wrap;  // forced angle reduced to one turn
  wire        hold_align;   // align hold in force
  wire        hold_slow;    // slow-first-cycle hold in force
  wire        hold_pos;     // position detect hold in force
  wire        hold_speed;   // speed detect hold in force
  wire        loop_off;     // closed loop disabled

  // register write; reserved low bits never store anything
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `DBG1_RESET; // [R11]
    end else if (reg_wr && (reg_addr == `DBG1_OFFSET)) begin
      ctrl_q <= reg_wdata & `DBG1_WRITE_MASK; // [R13]
    end
  end

  // register read; unmapped offsets answer zero so the bus never stalls
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q  <= 32'h0000_0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd && (reg_addr == `DBG1_OFFSET)) begin
        reg_rdata_q <= ctrl_q & `DBG1_WRITE_MASK; // [R13]
      end else if (reg_rd) begin
        reg_rdata_q <= 32'h0000_0000;
      end
    end
  end

  // field decode
  assign dig_speed  = ctrl_q[`DIG_SPEED_MSB:`DIG_SPEED_LSB]; // [R03]
  assign loop_off   = ctrl_q[`LOOP_OFF_BIT];
  assign hold_align = ctrl_q[`HOLD_ALIGN_BIT] &&
                      ((startup_method == `METHOD_ALIGN) ||
                       (startup_method == `METHOD_DOUBLE_ALIGN)); // [R06]
  assign hold_slow  = ctrl_q[`HOLD_SLOW_BIT] &&
                      (startup_method == `METHOD_SLOW_FIRST); // [R07]
  assign hold_pos   = ctrl_q[`HOLD_POS_BIT] &&
                      (startup_method == `METHOD_POS_DETECT); // [R08]
  assign hold_speed = ctrl_q[`HOLD_SPEED_BIT] && speed_detect_enable; // [R09]

  // speed source: selector bit overrides whatever mode is configured
  assign use_digital = ctrl_q[`SPEED_SRC_BIT] ||
                       (speed_mode == `SPEED_MODE_DIGITAL); // [R01] [R03]
  assign speed_sel   = use_digital ? dig_speed : input_speed_ref; // [R02]
  // full scale 32768 maps to 100 percent; truncation keeps the result below 100
  assign pct_product = {7'h00, speed_sel} * {15'h0000, `PERCENT_SCALE}; // [R04]

  // forced angle reduction
  angle_wrap u_angle_wrap (
    .angle_in  (forced_angle_cmd),
    .angle_out (forced_wrap)
  );

  // registered speed outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_ref_q      <= 15'h0000;
      speed_pct_q      <= 7'h00;
      digital_source_q <= 1'b0;
    end else begin
      speed_ref_q      <= speed_sel;
      speed_pct_q      <= pct_product[`PERCENT_SHIFT+6:`PERCENT_SHIFT]; // [R04]
      digital_source_q <= use_digital;
    end
  end

  // align angle: configured angle or wrapped command
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      align_angle_q <= 9'h000;
    end else if (ctrl_q[`ANGLE_SRC_BIT]) begin
      align_angle_q <= forced_wrap; // [R10] [R12]
    end else begin
      align_angle_q <= align_angle_cfg; // [R10]
    end
  end

  // state that the configured start-up method begins in
  always @* begin
    case (startup_method)
      `METHOD_ALIGN:        method_state = ST_ALIGN;
      `METHOD_DOUBLE_ALIGN: method_state = ST_ALIGN;
      `METHOD_SLOW_FIRST:   method_state = ST_SLOW;
      `METHOD_POS_DETECT:   method_state = ST_POS;
      default:              method_state = ST_ALIGN;
    endcase
  end

  // start-up sequencer; a hold bit freezes its phase even when step_done arrives
  always @* begin
    state_d      = startup_state_q;
    align_pass_d = align_pass_q;
    if (!motor_enable) begin
      state_d      = ST_IDLE;
      align_pass_d = 1'b0;
    end else begin
      case (startup_state_q)
        ST_IDLE: begin
          align_pass_d = 1'b0;
          state_d = speed_detect_enable ? ST_SPEED : method_state;
        end
        ST_SPEED: begin
          if (step_done && !hold_speed) begin // [R09]
            state_d = method_state;
          end
        end
        ST_ALIGN: begin
          // double align needs two finished passes before leaving
          if (step_done && !hold_align) begin // [R06]
            if ((startup_method == `METHOD_DOUBLE_ALIGN) && !align_pass_q) begin
              align_pass_d = 1'b1;
            end else begin
              state_d = ST_OPEN;
            end
          end
        end
        ST_SLOW: begin
          if (step_done && !hold_slow) begin // [R07]
            state_d = ST_OPEN;
          end
        end
        ST_POS: begin
          if (step_done && !hold_pos) begin // [R08]
            state_d = ST_OPEN;
          end
        end
        ST_OPEN: begin
          if (step_done && !loop_off) begin // [R05]
            state_d = ST_CLOSED;
          end
        end
        ST_CLOSED: begin
          if (loop_off) begin // [R05]
            state_d = ST_OPEN;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer registers; closed-loop flag follows the next state so it is a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      startup_state_q <= ST_IDLE;
      align_pass_q    <= 1'b0;
      closed_loop_q   <= 1'b0;
    end else begin
      startup_state_q <= state_d;
      align_pass_q    <= align_pass_d;
      closed_loop_q   <= (state_d == ST_CLOSED); // [R05]
    end
  end
endmodule

// >>> algo_debug_defs.vh
// register offset, field positions, reset value and codes of the algorithm debug control register
`ifndef ALGO_DEBUG_DEFS_VH
`define ALGO_DEBUG_DEFS_VH

`define DBG1_OFFSET          8'hEC
`define DBG1_RESET           32'h0000_0000
`define DBG1_WRITE_MASK      32'hFFFF_FC00
`define SPEED_SRC_BIT        31
`define DIG_SPEED_MSB        30
`define DIG_SPEED_LSB        16
`define LOOP_OFF_BIT         15
`define HOLD_ALIGN_BIT       14
`define HOLD_SLOW_BIT        13
`define HOLD_POS_BIT         12
`define HOLD_SPEED_BIT       11
`define ANGLE_SRC_BIT        10
`define SPEED_MODE_DIGITAL   2'h2
`define METHOD_ALIGN         2'h0
`define METHOD_DOUBLE_ALIGN  2'h1
`define METHOD_SLOW_FIRST    2'h2
`define METHOD_POS_DETECT    2'h3
`define PERCENT_SCALE        7'h64
`define PERCENT_SHIFT        15
`define ANGLE_FULL_TURN      9'h168

`endif

// >>> angle_wrap.v
// reduces a 9-bit angle in degrees to the range 0 to 359
`timescale 1ns/1ps
`include "algo_debug_defs.vh"

module angle_wrap (
  angle_in,
  angle_out
);
  input  wire [8:0] angle_in;   // raw commanded angle, 0 to 511
  output wire [8:0] angle_out;  // angle modulo one full turn

  // one subtraction is enough: 511 minus 360 is already below 360
  assign angle_out = (angle_in >= `ANGLE_FULL_TURN) ?
                     (angle_in - `ANGLE_FULL_TURN) : angle_in;
endmodule

// >>> ctl_model.sv
// external controller model issuing single register transfers
`timescale 1ns/1ps
module ctl_model (
  input  wire        clk,
  output reg  [7:0]  reg_addr,
  output reg  [31:0] reg_wdata,
  output reg         reg_wr,
  output reg         reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one strobe per call; lines are scrambled afterwards since nothing qualifies them
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_addr <= ~a;
      reg_wdata <= ~d;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the algorithm debug control register
`timescale 1ns/1ps
module testbench;
  reg         clk, rst, speed_detect_enable, motor_enable, step_done;  // single-bit inputs
  reg  [1:0]  speed_mode, startup_method;                              // configuration
  reg  [14:0] input_speed_ref, rv;                                     // reference, expected
  reg  [8:0]  align_angle_cfg, forced_angle_cmd;                       // angles
  wire [7:0]  reg_addr;                                                // bus from the model
  wire [31:0] reg_wdata, reg_rdata_q;                                  // bus words
  wire        reg_wr, reg_rd, reg_rvalid_q, digital_source_q, closed_loop_q;
  wire [14:0] speed_ref_q;
  wire [6:0]  speed_pct_q;
  wire [2:0]  startup_state_q;
  wire [8:0]  align_angle_q;
  integer     err_total, check_count, seed, i;
  reg  [31:0] w, q[$];                                                 // word, read notes
  reg  [2:0]  st;                                                      // expected held state
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ctl_model m (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  algo_debug_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .speed_mode(speed_mode), .input_speed_ref(input_speed_ref), .startup_method(startup_method),
    .speed_detect_enable(speed_detect_enable), .align_angle_cfg(align_angle_cfg),
    .forced_angle_cmd(forced_angle_cmd), .motor_enable(motor_enable), .step_done(step_done),
    .speed_ref_q(speed_ref_q), .speed_pct_q(speed_pct_q), .digital_source_q(digital_source_q),
    .startup_state_q(startup_state_q), .closed_loop_q(closed_loop_q),
    .align_angle_q(align_angle_q));
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (e !== g) begin
        err_total = err_total + 1;
        $display("FAIL %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task summarize;
    begin
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // one-cycle phase-done pulse, then let the sequencer settle
  task pulse;
    begin
      @(posedge clk);
      step_done <= 1'b1;
      @(posedge clk);
      step_done <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // each read answer is matched against the oldest note, away from the launching edge
  always @(negedge clk)
    if (reg_rvalid_q === 1'b1) chk("read", q.pop_front(), reg_rdata_q);
  // run takes a few hundred cycles; far beyond that means a hang
  initial begin
    #400000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    {speed_detect_enable, motor_enable, step_done, speed_mode, startup_method} = 0;
    {input_speed_ref, align_angle_cfg, forced_angle_cmd} = 0;
    err_total = 0;
    check_count = 0;
    seed = 32'h79dd_340d;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    q.push_back(32'h0000_0000);
    m.xfer(1'b0, 8'hEC, 32'h0000_0000);
    q.push_back(32'h0000_0000);
    m.xfer(1'b0, 8'hEE, 32'h0000_0000);
    // random words; a stray write elsewhere must not disturb the stored word
    for (i = 0; i < 16; i = i + 1) begin
      w = $random(seed);
      speed_mode <= $random(seed);
      input_speed_ref <= $random(seed);
      align_angle_cfg <= $random(seed);
      forced_angle_cmd <= $random(seed);
      m.xfer(1'b1, 8'hEC, w);
      m.xfer(1'b1, 8'hF0, ~w);
      q.push_back(w & 32'hFFFF_FC00);
      m.xfer(1'b0, 8'hEC, 32'h0000_0000);
      @(negedge clk);
      rv = (w[31] || speed_mode == 2'h2) ? w[30:16] : input_speed_ref;
      chk("source", w[31] || speed_mode == 2'h2, digital_source_q);
      chk("speed", rv, speed_ref_q);
      chk("percent", (rv * 7'h64) >> 15, speed_pct_q);
      chk("angle", w[10] ? forced_angle_cmd % 9'h168 : align_angle_cfg, align_angle_q);
    end
    // every hold bit against the start-up path that it freezes
    for (i = 0; i < 5; i = i + 1) begin
      startup_method <= (i == 4) ? 2'h0 : i;
      speed_detect_enable <= (i == 4);
      st = (i < 2) ? 3'h2 : (i == 4) ? 3'h1 : i + 1;
      m.xfer(1'b1, 8'hEC, 32'h0000_0001 << ((i == 0) ? 14 : 15 - i));
      motor_enable <= 1'b1;
      pulse;
      chk("held", st, startup_state_q);
      m.xfer(1'b1, 8'hEC, 32'h0000_0000);
      pulse;
      pulse;
      chk("released", 1'b1, startup_state_q !== st);
      motor_enable <= 1'b0;
      repeat (2) @(posedge clk);
    end
    // open loop while the loop-off bit stands, closed once it is cleared
    startup_method <= 2'h0;
    speed_detect_enable <= 1'b0;
    motor_enable <= 1'b1;
    m.xfer(1'b1, 8'hEC, 32'h0000_8000);
    pulse;
    pulse;
    chk("open", 3'h5, startup_state_q);
    m.xfer(1'b1, 8'hEC, 32'h0000_0000);
    pulse;
    chk("closed", 1'b1, closed_loop_q);
    m.xfer(1'b1, 8'hEC, 32'hFFFF_FFFF);
    repeat (2) @(posedge clk);
    #1;
    chk("dropped", 1'b0, closed_loop_q);
    // a second reset clears the word again; raised on a rising edge like the bus strobes and step_done
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    q.push_back(32'h0000_0000);
    m.xfer(1'b0, 8'hEC, 32'h0000_0000);
    repeat (3) @(posedge clk);
    // every noted read must have been answered
    chk("reads left", 32'h0000_0000, q.size());
    summarize;
  end
endmodule
